// >>> dv/sewp_host_model.sv
// spi host model that frames commands toward the eeprom write-protect block
`timescale 1ns/1ps
`default_nettype none
module sewp_host_model (
    output logic cs_n,          // chip select, active low
    output logic sck,           // serial clock, mode 0, still outside frames
    output logic si,            // serial data toward the device
    input wire logic so_out,    // serial data from the device
    input wire logic so_oe      // device drives its data output
);
    localparam time HALF = 24;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one frame: n bits from the top of d, last eight bits seen on so in rd
    task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rd);
        rd = 8'h00;
        cs_n = 1'b0;
        #HALF;
        for (int i = 0; i < n; i++) begin
            si = d[39 - i];
            #HALF;
            sck = 1'b1;
            if (so_oe === 1'b1) rd = {rd[6:0], so_out};
            #HALF;
            sck = 1'b0;
        end
        #HALF;
        cs_n = 1'b1;
        // no pull on the data line, so it must not keep its last level
        si = ~si;
        #(4 * HALF);
    endtask
endmodule // sewp_host_model
`default_nettype wire

// >>> dv/tb_serial_eeprom_write_protect.sv
// self-checking bench for the eeprom write-protect block against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_write_protect;
    logic mclk, reset_n, wp_n, prog_done;
    wire cs_n, sck, si;
    logic so_out, so_oe, standby, write_latch_flag, write_busy_flag, pin_protect_enable, hw_protect;
    logic array_write_start, status_write_start;
    logic [1:0] block_protect;
    logic [10:0] write_addr, cap_addr;
    logic m_latch, m_busy, m_ppe, m_wp;
    logic [1:0] m_bp;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_arr = 0;
    int n_st = 0;
    int n_sel = 0;
    int addrs[$] = '{0, 'h3FF, 'h400, 'h5FF, 'h600, 'h7FF};

    sewp_protect i_dut (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .prog_done(prog_done), .so_out(so_out), .so_oe(so_oe), .standby(standby),
        .write_latch_flag(write_latch_flag), .write_busy_flag(write_busy_flag),
        .pin_protect_enable(pin_protect_enable), .block_protect(block_protect), .hw_protect(hw_protect),
        .array_write_start(array_write_start), .status_write_start(status_write_start),
        .write_addr(write_addr));
    sewp_host_model i_host (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (array_write_start === 1'b1) begin
            n_arr++;
            cap_addr <= write_addr;
        end
        if (status_write_start === 1'b1) n_st++;
        if (standby === 1'b0) n_sel++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic bit prot(input logic [1:0] bp, input int a);
        return (bp == 2'h1 && a >= 1536) || (bp == 2'h2 && a >= 1024) || bp == 2'h3;
    endfunction
    task automatic cmp_state;
        chk("latch", m_latch, write_latch_flag);
        chk("busy", m_busy, write_busy_flag);
        chk("pin enable", m_ppe, pin_protect_enable);
        chk("block protect", m_bp, block_protect);
        chk("hw protect", m_ppe & ~m_wp, hw_protect);
        chk("standby", 1'b1, standby);
        chk("so enable", 1'b0, so_oe);
    endtask
    task automatic xfer(input logic [7:0] op, input logic [23:0] rest, input int n);
        int a0;
        int s0;
        int adr;
        bit ok_arr;
        bit ok_st;
        logic [7:0] rd;
        int l0;
        a0 = n_arr;
        s0 = n_st;
        adr = rest[18:8];
        ok_arr = 0;
        ok_st = 0;
        l0 = n_sel;
        // frames start just after a clock edge so pin changes never race the sampling edge
        @(posedge mclk);
        #1;
        i_host.frame({op, rest, 8'h5A}, n, rd);
        chk("selected", 1'b1, n_sel > l0);
        if (op == 8'h05) chk("status byte", {m_ppe, 3'b000, m_bp, m_latch, m_busy}, rd);
        if (!m_busy) begin
            if (op == 8'h06 && n == 8) m_latch = 1'b1;
            if (op == 8'h04 && n == 8) m_latch = 1'b0;
            if (op == 8'h01 && n == 16 && m_latch && !(m_ppe && !m_wp)) begin
                ok_st = 1;
                m_ppe = rest[23];
                m_bp = rest[19:18];
                m_busy = 1'b1;
            end
            if (op == 8'h02 && n >= 32 && n % 8 == 0 && m_latch && !prot(m_bp, adr)) begin
                ok_arr = 1;
                m_busy = 1'b1;
            end
        end
        chk("array start", ok_arr, n_arr - a0);
        chk("status start", ok_st, n_st - s0);
        if (ok_arr) chk("write addr", adr, cap_addr);
        cmp_state;
    endtask
    task automatic finish_prog;
        @(posedge mclk);
        #1 prog_done = 1'b1;
        @(posedge mclk);
        #1 prog_done = 1'b0;
        repeat (3) @(posedge mclk);
        if (m_busy) begin
            m_busy = 1'b0;
            m_latch = 1'b0;
        end
        cmp_state;
    endtask
    task automatic set_wp(input logic v);
        @(posedge mclk);
        #1 wp_n = v;
        m_wp = v;
        repeat (6) @(posedge mclk);
        cmp_state;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300_000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        logic [31:0] r;
        reset_n = 1'b0;
        wp_n = 1'b1;
        prog_done = 1'b0;
        {m_latch, m_busy, m_ppe, m_bp} = '0;
        m_wp = 1'b1;
        r = $urandom(32'h1B68047E);
        addrs.push_back(r[10:0]);
        repeat (5) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (6) @(posedge mclk);
        cmp_state;
        xfer(8'h02, {16'h0010, 8'hA5}, 32);
        xfer(8'h06, 24'h0, 8);
        xfer(8'h04, 24'h0, 8);
        xfer(8'h06, 24'h0, 9);
        xfer(8'h07, 24'h0, 8);
        xfer(8'h06, 24'h0, 8);
        xfer(8'h02, {16'h0020, 8'h77}, 31);
        for (int b = 0; b < 4; b++) begin
            r = $urandom;
            xfer(8'h06, 24'h0, 8);
            xfer(8'h01, {(r[7:0] & 8'h73) | 8'(b << 2), 16'h0}, 16);
            finish_prog;
            foreach (addrs[i]) begin
                r = $urandom;
                xfer(8'h06, 24'h0, 8);
                xfer(8'h02, {r[15:11], 11'(addrs[i]), r[7:0]}, (i % 2) ? 40 : 32);
                finish_prog;
            end
        end
        xfer(8'h06, 24'h0, 8);
        xfer(8'h01, {8'h80, 16'h0}, 16);
        finish_prog;
        xfer(8'h06, 24'h0, 8);
        xfer(8'h02, {16'h0100, 8'h3C}, 32);
        xfer(8'h04, 24'h0, 8);
        xfer(8'h06, 24'h0, 8);
        xfer(8'h02, {16'h0200, 8'hC3}, 32);
        xfer(8'h05, 24'h0, 16);
        finish_prog;
        set_wp(1'b0);
        xfer(8'h06, 24'h0, 8);
        xfer(8'h01, {8'h08, 16'h0}, 16);
        xfer(8'h02, {16'h0700, 8'h11}, 32);
        finish_prog;
        xfer(8'h05, 24'h0, 16);
        set_wp(1'b1);
        xfer(8'h06, 24'h0, 8);
        xfer(8'h01, 24'h0, 16);
        finish_prog;
        // a reset in mid-run must drop a set latch again
        xfer(8'h06, 24'h0, 8);
        @(posedge mclk);
        #1 reset_n = 1'b0;
        repeat (5) @(posedge mclk);
        #1 reset_n = 1'b1;
        {m_latch, m_busy, m_ppe, m_bp} = '0;
        repeat (6) @(posedge mclk);
        cmp_state;
        xfer(8'h05, 24'h0, 16);
        give_verdict;
    end
endmodule // tb_serial_eeprom_write_protect
`default_nettype wire

// >>> rtl/sewp_pkg.sv
// constants, command codes and protection decode for the eeprom write-protect block
`default_nettype none
package sewp_pkg;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

    // status byte bit positions
    localparam int ST_PPE = 7;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_LATCH = 1;
    localparam int ST_BUSY = 0;

    localparam int CNT_W = 9;
    localparam logic [8:0] CNT_ZERO = 9'h000;
    localparam logic [8:0] CNT_ONE = 9'h001;
    localparam logic [8:0] CNT_CMD = 9'h008;
    localparam logic [8:0] CNT_STATUS = 9'h010;
    localparam logic [8:0] CNT_ADDR = 9'h018;
    localparam logic [8:0] CNT_FIRST_DATA = 9'h020;
    localparam logic [8:0] CNT_MAX = 9'h1FF;
    localparam logic [2:0] BYTE_EDGE = 3'h0;

    localparam int ADDR_W = 11;
    localparam logic [10:0] SEG_QUARTER = 11'h600;
    localparam logic [10:0] SEG_HALF = 11'h400;
    localparam logic [10:0] ADDR_RESET = 11'h000;

    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;

    // synchroniser lanes and their reset levels
    localparam int SY_W = 4;
    localparam int SY_CS = 0;
    localparam int SY_WP = 1;
    localparam int SY_SCK = 2;
    localparam int SY_SI = 3;
    localparam logic [3:0] SY_RST = 4'h3;

    typedef enum logic [2:0] {
        SEWP_CMD_NONE,
        SEWP_CMD_LATCH_SET,
        SEWP_CMD_LATCH_CLEAR,
        SEWP_CMD_STATUS_WRITE,
        SEWP_CMD_STATUS_READ,
        SEWP_CMD_ARRAY_WRITE,
        SEWP_CMD_OTHER
    } sewp_cmd_e;

    function automatic logic sewp_is_protected(input logic [1:0] bp, input logic [10:0] addr);
        logic prot;
        prot = 1'b0;
        case (bp)
            BP_NONE: prot = 1'b0;
            BP_QUARTER: prot = (addr >= SEG_QUARTER);
            BP_HALF: prot = (addr >= SEG_HALF);
            BP_ALL: prot = 1'b1;
            default: prot = 1'b1;
        endcase
        return prot;
    endfunction
endpackage
`default_nettype wire

// >>> rtl/sewp_protect.sv
// write-protect, write latch and status logic of the serial eeprom
// Function
// - status write selects one of four protection levels
// - block-protect code maps to protected address range
// - writes into protected segments always rejected
// - pin-protect enable is a stored status bit
// - hardware protect when pin low and enable set
// - no hardware protect if pin high or enable clear
// - hardware protect blocks only status bit writes
// - write latch cleared at power-up
// - latch cleared when a write completes
// - internal write starts only on select release
// - commands other than status read ignored while internal write is busy
// - standby with select high after power-up
// - serial output undriven until an operation drives it
// - command codes fixed, sent most significant first
// - status byte bit layout fixed
// - latch-clear command clears the write latch
// - block-protect bits change only by status write
`timescale 1ns/1ps
`default_nettype none
module sewp_protect (
    input wire logic mclk,                 // core clock, 250 MHz
    input wire logic reset_n,              // async power-on reset, active low
    input wire logic cs_n,                 // chip select pin, active low
    input wire logic sck,                  // serial clock pin
    input wire logic si,                   // serial data in pin
    input wire logic wp_n,                 // write-protect pin, active low
    input wire logic prog_done,            // programming finished pulse
    output logic so_out,                   // serial data out value
    output logic so_oe,                    // serial data out drive enable
    output logic standby,                  // device deselected
    output logic write_latch_flag,         // write enable latch
    output logic write_busy_flag,          // internal write in progress
    output logic pin_protect_enable,       // stored pin-protect enable
    output logic [1:0] block_protect,      // stored block-protect code
    output logic hw_protect,               // hardware protection active
    output logic array_write_start,        // array write start pulse
    output logic status_write_start,       // status write start pulse
    output logic [10:0] write_addr         // array write start address
);
    logic [3:0] sync_q;
    logic cs_s;
    logic wp_s;
    logic sck_s;
    logic si_s;
    logic cs_q;
    logic sck_q;
    logic [8:0] count;
    logic [7:0] shift;
    logic [7:0] so_shift;
    logic [7:0] status_data;
    sewp_pkg::sewp_cmd_e cmd;

    logic next_cs_q;
    logic next_sck_q;
    logic [8:0] next_count;
    logic [7:0] next_shift;
    logic [7:0] next_so_shift;
    logic [7:0] next_status_data;
    sewp_pkg::sewp_cmd_e next_cmd;
    logic next_so_out;
    logic next_so_oe;
    logic next_standby;
    logic next_latch;
    logic next_busy;
    logic next_ppe;
    logic [1:0] next_bp;
    logic next_hw_protect;
    logic next_array_start;
    logic next_status_start;
    logic [10:0] next_addr;

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic [8:0] cnt_inc;
    logic [7:0] shifted;
    logic [7:0] status_byte;
    logic latch_set;
    logic latch_clear;

    sewp_sync #(
        .W(sewp_pkg::SY_W),
        .RST(sewp_pkg::SY_RST)
    ) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .d({si, sck, wp_n, cs_n}),
        .q(sync_q)
    );

    assign cs_s = sync_q[sewp_pkg::SY_CS];
    assign wp_s = sync_q[sewp_pkg::SY_WP];
    assign sck_s = sync_q[sewp_pkg::SY_SCK];
    assign si_s = sync_q[sewp_pkg::SY_SI];

    ////////////////////////////////////////////////////////////////////////
    // serial framing, protection and status
    always_comb begin
        sck_rise = sck_s & ~sck_q;
        sck_fall = ~sck_s & sck_q;
        cs_rise = cs_s & ~cs_q;
        cnt_inc = count + sewp_pkg::CNT_ONE;
        shifted = {shift[6:0], si_s};
        status_byte = 8'h00;
        status_byte[sewp_pkg::ST_PPE] = pin_protect_enable;
        status_byte[sewp_pkg::ST_BP_HI] = block_protect[1];
        status_byte[sewp_pkg::ST_BP_LO] = block_protect[0];
        status_byte[sewp_pkg::ST_LATCH] = write_latch_flag;
        status_byte[sewp_pkg::ST_BUSY] = write_busy_flag;
        latch_set = 1'b0;
        latch_clear = 1'b0;

        next_cs_q = cs_s;
        next_sck_q = sck_s;
        next_count = count;
        next_shift = shift;
        next_so_shift = so_shift;
        next_status_data = status_data;
        next_cmd = cmd;
        next_so_out = so_out;
        next_so_oe = so_oe;
        next_standby = cs_s;
        next_ppe = pin_protect_enable;
        next_bp = block_protect;
        next_hw_protect = ~wp_s & pin_protect_enable;
        next_array_start = 1'b0;
        next_status_start = 1'b0;
        next_addr = write_addr;

        if (cs_s) begin
            next_count = sewp_pkg::CNT_ZERO;
            next_cmd = sewp_pkg::SEWP_CMD_NONE;
            next_so_oe = 1'b0;
        end else if (sck_rise) begin
            next_shift = shifted;
            if (count != sewp_pkg::CNT_MAX) begin
                next_count = cnt_inc;
            end
            if (cnt_inc == sewp_pkg::CNT_CMD) begin
                case (shifted)
                    sewp_pkg::OP_LATCH_SET: next_cmd = sewp_pkg::SEWP_CMD_LATCH_SET;
                    sewp_pkg::OP_LATCH_CLEAR: next_cmd = sewp_pkg::SEWP_CMD_LATCH_CLEAR;
                    sewp_pkg::OP_STATUS_WRITE: next_cmd = sewp_pkg::SEWP_CMD_STATUS_WRITE;
                    sewp_pkg::OP_STATUS_READ: next_cmd = sewp_pkg::SEWP_CMD_STATUS_READ;
                    sewp_pkg::OP_ARRAY_WRITE: next_cmd = sewp_pkg::SEWP_CMD_ARRAY_WRITE;
                    default: next_cmd = sewp_pkg::SEWP_CMD_OTHER;
                endcase
                // only the status may be read while programming runs
                if (write_busy_flag && shifted != sewp_pkg::OP_STATUS_READ) begin
                    next_cmd = sewp_pkg::SEWP_CMD_OTHER;
                end
            end
            if (cmd == sewp_pkg::SEWP_CMD_ARRAY_WRITE &&
                (cnt_inc == sewp_pkg::CNT_STATUS || cnt_inc == sewp_pkg::CNT_ADDR)) begin
                next_addr = {write_addr[2:0], shifted};
            end
            if (cmd == sewp_pkg::SEWP_CMD_STATUS_WRITE && cnt_inc == sewp_pkg::CNT_STATUS) begin
                next_status_data = shifted;
            end
        end else if (sck_fall && cmd == sewp_pkg::SEWP_CMD_STATUS_READ) begin
            next_so_oe = 1'b1;
            if (count[2:0] == sewp_pkg::BYTE_EDGE) begin
                next_so_out = status_byte[7];
                next_so_shift = {status_byte[6:0], 1'b0};
            end else begin
                next_so_out = so_shift[7];
                next_so_shift = {so_shift[6:0], 1'b0};
            end
        end

        // latch and write commands take effect only at the select release
        if (cs_rise) begin
            case (cmd)
                sewp_pkg::SEWP_CMD_LATCH_SET: begin
                    latch_set = (count == sewp_pkg::CNT_CMD);
                end
                sewp_pkg::SEWP_CMD_LATCH_CLEAR: begin
                    latch_clear = (count == sewp_pkg::CNT_CMD);
                end
                sewp_pkg::SEWP_CMD_STATUS_WRITE: begin
                    if (count == sewp_pkg::CNT_STATUS && write_latch_flag && !hw_protect) begin
                        next_status_start = 1'b1;
                        next_ppe = status_data[sewp_pkg::ST_PPE];
                        next_bp = {status_data[sewp_pkg::ST_BP_HI], status_data[sewp_pkg::ST_BP_LO]};
                    end
                end
                sewp_pkg::SEWP_CMD_ARRAY_WRITE: begin
                    if (count >= sewp_pkg::CNT_FIRST_DATA && count[2:0] == sewp_pkg::BYTE_EDGE &&
                        write_latch_flag && !sewp_pkg::sewp_is_protected(block_protect, write_addr)) begin
                        next_array_start = 1'b1;
                    end
                end
                default: begin
                    latch_set = 1'b0;
                end
            endcase
        end

        // a latch set arriving with a completion still wins
        next_latch = (write_latch_flag & ~latch_clear & ~(write_busy_flag & prog_done)) | latch_set;
        next_busy = (write_busy_flag & ~prog_done) | next_array_start | next_status_start;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cs_q <= 1'b1;
            sck_q <= 1'b0;
            count <= sewp_pkg::CNT_ZERO;
            shift <= 8'h00;
            so_shift <= 8'h00;
            status_data <= 8'h00;
            cmd <= sewp_pkg::SEWP_CMD_NONE;
            so_out <= 1'b0;
            so_oe <= 1'b0;
            standby <= 1'b1;
            write_latch_flag <= 1'b0;
            write_busy_flag <= 1'b0;
            pin_protect_enable <= 1'b0;
            block_protect <= sewp_pkg::BP_NONE;
            hw_protect <= 1'b0;
            array_write_start <= 1'b0;
            status_write_start <= 1'b0;
            write_addr <= sewp_pkg::ADDR_RESET;
        end else begin
            cs_q <= next_cs_q;
            sck_q <= next_sck_q;
            count <= next_count;
            shift <= next_shift;
            so_shift <= next_so_shift;
            status_data <= next_status_data;
            cmd <= next_cmd;
            so_out <= next_so_out;
            so_oe <= next_so_oe;
            standby <= next_standby;
            write_latch_flag <= next_latch;
            write_busy_flag <= next_busy;
            pin_protect_enable <= next_ppe;
            block_protect <= next_bp;
            hw_protect <= next_hw_protect;
            array_write_start <= next_array_start;
            status_write_start <= next_status_start;
            write_addr <= next_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_HW_ON: assert property (@(posedge mclk) disable iff (!reset_n)
        (!wp_s && pin_protect_enable) |=> hw_protect)
        else $error("hardware protect not entered");
    AST_HW_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
        (wp_s || !pin_protect_enable) |=> !hw_protect)
        else $error("hardware protect active while disabled");
    AST_NO_PROT_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
        array_write_start |-> !sewp_pkg::sewp_is_protected(block_protect, write_addr))
        else $error("write started into protected segment");
    AST_LATCH_NEEDED: assert property (@(posedge mclk) disable iff (!reset_n)
        (array_write_start || status_write_start) |-> $past(write_latch_flag))
        else $error("write started with latch clear");
    AST_HWP_STATUS: assert property (@(posedge mclk) disable iff (!reset_n)
        status_write_start |-> !$past(hw_protect))
        else $error("status written under hardware protect");
    AST_LATCH_DONE: assert property (@(posedge mclk) disable iff (!reset_n)
        (write_busy_flag && prog_done) |=> !write_latch_flag && !write_busy_flag)
        else $error("latch or busy not cleared at completion");
    AST_BUSY_IGNORE: assert property (@(posedge mclk) disable iff (!reset_n)
        write_busy_flag |=> !array_write_start && !status_write_start)
        else $error("write started while busy");
    AST_SO_HIZ: assert property (@(posedge mclk) disable iff (!reset_n)
        cs_s |=> !so_oe)
        else $error("output driven while deselected");
    AST_CS_RISE: assert property (@(posedge mclk) disable iff (!reset_n)
        (array_write_start || status_write_start) |-> $past(cs_s) && !$past(cs_q))
        else $error("write started without select release");
    AST_NV_ONLY_SW: assert property (@(posedge mclk) disable iff (!reset_n)
        ($changed(block_protect) || $changed(pin_protect_enable)) |-> status_write_start)
        else $error("stored bits changed outside status write");
    AST_STANDBY: assert property (@(posedge mclk) disable iff (!reset_n)
        standby |-> ##0 $past(cs_s))
        else $error("standby does not follow select");

    COV_ARRAY_WRITE: cover property (@(posedge mclk) disable iff (!reset_n) array_write_start);
    COV_STATUS_WRITE: cover property (@(posedge mclk) disable iff (!reset_n) status_write_start);
    COV_HW_PROTECT: cover property (@(posedge mclk) disable iff (!reset_n) $rose(hw_protect));
    COV_STATUS_READ: cover property (@(posedge mclk) disable iff (!reset_n) $rose(so_oe));
endmodule // sewp_protect
`default_nettype wire

// >>> rtl/sewp_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sewp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk,         // core clock
    input wire logic reset_n,      // async reset, active low
    input wire logic [W-1:0] d,    // asynchronous inputs
    output logic [W-1:0] q         // synchronised outputs
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= RST;
            q <= RST;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule // sewp_sync
`default_nettype wire
